// ==== rtl/tac_pkg.sv ====
package tac_pkg;
   localparam int TAC_NCH = 8;
   localparam int TAC_RES_W = 10;
   localparam int TAC_CLKDIV_W = 6;
   localparam logic [5:0] TAC_PRESCAL_RST = 6'h00;
   localparam logic [6:0] TAC_STARTUP_RST = 7'h00;
   localparam logic [3:0] TAC_SAMPLE_HOLD_CYCLES_RST = 4'h0;
   localparam logic [9:0] TAC_CONV_CYCLES = 10'h00a;
   localparam logic [15:0] TAC_TIMER_RST = 16'h0000;
   localparam int TAC_STARTUP_STEP_LOG2 = 3;
   localparam int TAC_TS_NCONV = 4;
   typedef enum logic [2:0] {
      TAC_IDLE = 3'b000,
      TAC_WAKE = 3'b001,
      TAC_PICK = 3'b010,
      TAC_SAMPLE = 3'b011,
      TAC_CONV = 3'b100,
      TAC_STORE = 3'b101
   } tac_state_t;
endpackage : tac_pkg

// ==== rtl/tac_result_mem.sv ====
module tac_result_mem
   import tac_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [TAC_RES_W-1:0] wr_data,
   input wire logic [3:0] rd_addr,
   output logic [TAC_RES_W-1:0] rd_data
);
   // Entries 0 to 7 hold channel results, 8 to 11 hold panel results.
   logic [TAC_RES_W-1:0] mem_q [0:15];
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule : tac_result_mem

// ==== rtl/tac_sequencer.sv ====
// Functional notes
// - Eight-to-one input select before each conversion.
// - Eight-bit or ten-bit result precision.
// - Result goes to last and channel registers.
// - Software, external edge, or timer starts sequence.
// - Touch mode timer sequence drives switches, stores.
// - Four panel switches measure both axes.
// - Fifth switch and resistor detect pen.
// - Sleep wakes on trigger, sleeps after sequence.
// - Only enabled channels are converted, apart from the touch panel reads on channels 1 and 3.
// - One DMA request per stored result.
// - Wake wait and sample time programmable.
// - Channel enable takes over the shared pin.
// - Inputs grounded after reset until enabled.
// - Configuration writable while clock gated.
// - Channels 0 to 3 double as electrodes.
// - Channels 4 to 7 are general only.
// - Single interrupt output for events.
// - Low precision zeroes top bits, byte DMA.
// - Panel conversions always ten-bit.
// - Conversion is sample cycles plus ten.
// - Wake wait is 8 to 1024 steps 8.
module tac_sequencer
   import tac_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [TAC_NCH-1:0] channel_enable_register,
   input wire logic low_precision_select,
   input wire logic sleep_mode,
   input wire logic touch_enable,
   input wire logic pen_detect_enable,
   input wire logic [5:0] prescale,
   input wire logic [6:0] startup_field,
   input wire logic [3:0] sample_hold_cycles,
   input wire logic [3:0] touch_sample_hold_cycles,
   input wire logic [15:0] timer_period,
   input wire logic timer_enable,
   input wire logic soft_trigger,
   input wire logic external_conversion_trigger,
   input wire logic pen_sense,
   input wire logic conv_done,
   input wire logic [TAC_RES_W-1:0] conv_result,
   input wire logic [3:0] read_index,
   input wire logic dma_ack,
   output logic [2:0] mux_select,
   output logic [TAC_NCH-1:0] pin_takeover,
   output logic [TAC_NCH-1:0] input_grounded,
   output logic cell_awake,
   output logic conv_start,
   output logic [3:0] panel_switch,
   output logic pen_switch,
   output logic [TAC_RES_W-1:0] last_result,
   output logic [3:0] last_index,
   output logic [TAC_RES_W-1:0] read_data,
   output logic dma_req,
   output logic dma_byte_size,
   output logic [TAC_RES_W-1:0] dma_data,
   output logic busy,
   output logic seq_done,
   output logic pen_contact,
   output logic irq
);
   tac_state_t state_q, state_d;
   logic [2:0] trg_sync_q;
   logic [1:0] pen_sync_q;
   logic [5:0] div_q;
   logic adc_tick;
   logic [9:0] cnt_q;
   logic [15:0] tmr_q;
   logic tmr_fire;
   logic [TAC_NCH-1:0] pend_q;
   logic [2:0] ch_q;
   logic ts_mode_q;
   logic [1:0] ts_step_q;
   logic [TAC_RES_W-1:0] res_q;
   logic low_precision_select_q;
   logic done_q;
   logic pen_q;
   logic dma_q;
   logic [TAC_RES_W-1:0] dma_data_q;
   logic [TAC_RES_W-1:0] last_q;
   logic [3:0] last_idx_q;
   logic trigger;
   logic [9:0] wake_cycles;
   logic [9:0] sh_cycles;
   logic [TAC_RES_W-1:0] stored;
   logic [3:0] store_idx;
   logic store_en;
   logic seq_start;
   logic [3:0] first_pick;

   // Lowest set bit, used for picking; the start decision tests channel_enable_register directly.
   function automatic logic [3:0] tac_first(input logic [TAC_NCH-1:0] m);
      logic [3:0] r;
      r = 4'h8;
      for (int i = TAC_NCH - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction : tac_first

   // The external trigger pin passes two flops; the third feeds the edge detector.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         trg_sync_q <= 3'h0;
         pen_sync_q <= 2'h0;
      end else begin
         trg_sync_q <= {trg_sync_q[1:0], external_conversion_trigger};
         pen_sync_q <= {pen_sync_q[0], pen_sense};
      end
   end

   // Converter clock tick from the prescaler.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_q <= TAC_PRESCAL_RST;
      end else if (div_q >= prescale) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 6'h01;
      end
   end
   assign adc_tick = (div_q >= prescale);

   // Internal timer, counted in converter clock ticks.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tmr_q <= TAC_TIMER_RST;
      end else if (!timer_enable || tmr_fire) begin
         tmr_q <= TAC_TIMER_RST;
      end else if (adc_tick) begin
         tmr_q <= tmr_q + 16'h0001;
      end
   end
   assign tmr_fire = timer_enable && adc_tick && (tmr_q >= timer_period);

   assign trigger = soft_trigger || (trg_sync_q[1] && !trg_sync_q[2]) || tmr_fire;
   // A sequence with nothing to convert leaves idle only when touch_enable and timer_enable are both set.
   assign seq_start = (state_q == TAC_IDLE) && trigger
      && ((touch_enable && timer_enable) || (channel_enable_register != '0));
   assign wake_cycles = {startup_field, 3'h0} + 10'h007;
   assign sh_cycles = 10'((ts_mode_q ? touch_sample_hold_cycles : sample_hold_cycles));
   // One pick feeds both the channel register and the mask clear, so they cannot disagree.
   assign first_pick = tac_first(pend_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         TAC_IDLE: begin
            if (seq_start) begin
               state_d = sleep_mode ? TAC_WAKE : TAC_PICK;
            end
         end
         TAC_WAKE: begin
            if (adc_tick && cnt_q == wake_cycles) begin
               state_d = TAC_PICK;
            end
         end
         TAC_PICK: begin
            if (ts_mode_q || pend_q != '0) begin
               state_d = TAC_SAMPLE;
            end else begin
               state_d = TAC_IDLE;
            end
         end
         TAC_SAMPLE: begin
            if (adc_tick && cnt_q == sh_cycles) begin
               state_d = TAC_CONV;
            end
         end
         TAC_CONV: begin
            if (conv_done) begin
               state_d = TAC_STORE;
            end
         end
         TAC_STORE: begin
            state_d = TAC_PICK;
         end
         default: begin
            state_d = TAC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= TAC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Cycle counter for wake and sample-and-hold phases.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else if (state_q != state_d) begin
         cnt_q <= '0;
      end else if (adc_tick) begin
         cnt_q <= cnt_q + 10'h001;
      end
   end

   // Sequence bookkeeping: pending mask, current channel, panel step.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pend_q <= '0;
         ch_q <= '0;
         ts_mode_q <= 1'b0;
         ts_step_q <= '0;
         low_precision_select_q <= 1'b0;
      end else if (seq_start) begin
         ts_mode_q <= touch_enable && tmr_fire;
         ts_step_q <= '0;
         pend_q <= channel_enable_register;
         low_precision_select_q <= low_precision_select && !(touch_enable && tmr_fire);
      end else if (state_q == TAC_PICK && !ts_mode_q && pend_q != '0) begin
         ch_q <= first_pick[2:0];
         pend_q[first_pick[2:0]] <= 1'b0;
      end else if (state_q == TAC_PICK && ts_mode_q) begin
         ch_q <= ts_step_q[1] ? 3'h3 : 3'h1;
      end else if (state_q == TAC_STORE && ts_mode_q) begin
         ts_step_q <= ts_step_q + 2'h1;
         if (ts_step_q == 2'(TAC_TS_NCONV - 1)) begin
            ts_mode_q <= 1'b0;
         end
      end
   end

   // Panel phases 0/1 drive top-bottom and read right; 2/3 drive right-left.
   assign panel_switch = (ts_mode_q && (state_q == TAC_SAMPLE || state_q == TAC_CONV))
      ? (ts_step_q[1] ? 4'b1100 : 4'b0011) : 4'b0000;
   // Pen detection stands down while a panel conversion runs.
   assign pen_switch = pen_detect_enable && !(ts_mode_q && state_q != TAC_IDLE);

   assign mux_select = ch_q;
   assign pin_takeover = channel_enable_register;
   assign input_grounded = ~channel_enable_register;
   assign cell_awake = !sleep_mode || state_q != TAC_IDLE;
   assign conv_start = (state_q == TAC_SAMPLE) && (state_d == TAC_CONV);
   assign busy = (state_q != TAC_IDLE);

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_q <= '0;
      end else if (state_q == TAC_CONV && conv_done) begin
         res_q <= low_precision_select_q ? {2'b00, conv_result[9:2]} : conv_result;
      end
   end

   assign stored = res_q;
   assign store_en = (state_q == TAC_STORE);
   assign store_idx = ts_mode_q ? (4'h8 + {2'b00, ts_step_q}) : {1'b0, ch_q};

   tac_result_mem u_mem (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .wr_en(store_en),
      .wr_addr(store_idx),
      .wr_data(stored),
      .rd_addr(read_index),
      .rd_data(read_data)
   );

   // Last result, DMA request and events.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         last_q <= '0;
         last_idx_q <= '0;
         dma_q <= 1'b0;
         dma_data_q <= '0;
         done_q <= 1'b0;
         pen_q <= 1'b0;
      end else begin
         if (store_en) begin
            last_q <= stored;
            last_idx_q <= store_idx;
            dma_data_q <= stored;
         end
         // A new store wins over an acknowledge in the same cycle.
         if (store_en) begin
            dma_q <= 1'b1;
         end else if (dma_ack) begin
            dma_q <= 1'b0;
         end
         done_q <= (state_q == TAC_PICK) && (state_d == TAC_IDLE);
         pen_q <= pen_switch && pen_sync_q[1];
      end
   end

   assign last_result = last_q;
   assign last_index = last_idx_q;
   assign dma_req = dma_q;
   assign dma_data = dma_data_q;
   assign dma_byte_size = low_precision_select_q;
   assign seq_done = done_q;
   assign pen_contact = pen_q;
   assign irq = done_q || (pen_q != (pen_switch && pen_sync_q[1]));

   a_start_pulse_one: assert property (
      @(posedge core_clk) disable iff (sys_rst) conv_start |=> !conv_start)
      else $error("start pulse longer than one cycle");
   a_capture_after_done: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == TAC_CONV && conv_done) |=> (state_q == TAC_STORE) ##1 (last_q == res_q))
      else $error("result not captured after done");
   a_low_precision_select_top_zero: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == TAC_STORE && low_precision_select_q) |-> stored[9:8] == 2'b00)
      else $error("low precision top bits not zero");
   a_only_enabled_ch: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (conv_start && !ts_mode_q)
      |-> channel_enable_register[ch_q] || $changed(channel_enable_register))
      else $error("disabled channel converted");
   // A trigger during a conversion must leave the running sequence alone.
   a_busy_no_restart: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == TAC_CONV && trigger && !conv_done) |=> state_q == TAC_CONV)
      else $error("trigger accepted while busy");
   a_sleep_wake_path: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (seq_start && sleep_mode) |=> state_q == TAC_WAKE)
      else $error("sleep wake skipped");
   a_sleep_after_done: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (seq_done && sleep_mode) |-> !cell_awake)
      else $error("cell left awake after sequence");
   a_done_pulse_one: assert property (
      @(posedge core_clk) disable iff (sys_rst) seq_done |=> !seq_done)
      else $error("sequence done longer than one cycle");
   a_ground_disabled: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      input_grounded == ~channel_enable_register && pin_takeover == channel_enable_register)
      else $error("grounding mismatch");
   a_dma_on_store: assert property (
      @(posedge core_clk) disable iff (sys_rst) store_en |=> dma_req)
      else $error("no dma request after store");
   a_panel_tenbit: assert property (
      @(posedge core_clk) disable iff (sys_rst) ts_mode_q |-> !low_precision_select_q)
      else $error("panel conversion not ten-bit");
   a_panel_off_idle: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state_q == TAC_IDLE) |-> panel_switch == 4'h0)
      else $error("panel switches closed while idle");
   a_pen_off_panel: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (ts_mode_q && busy) |-> !pen_switch)
      else $error("pen switch closed during panel conversion");
endmodule : tac_sequencer

// ==== verif/tac_adc_model.sv ====
// Behavioural converter cell. It answers a start pulse after a fixed number of cycles.
module tac_adc_model
   import tac_pkg::*;
#(
   parameter int CONV_DELAY = 12
)
(
   input wire logic core_clk,
   input wire logic conv_start,
   input wire logic [2:0] mux_select,
   input wire logic [3:0] panel_switch,
   output logic conv_done,
   output logic [TAC_RES_W-1:0] conv_result
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic [TAC_RES_W-1:0] held;
   initial begin
      cnt = 0;
      held = 10'h000;
      conv_done = 1'b0;
      conv_result = 10'h000;
   end
   // The result line toggles outside its valid cycle so a late capture cannot pass by luck.
   always @(posedge core_clk) begin
      conv_done <= 1'b0;
      conv_result <= ~conv_result;
      if (conv_start === 1'b1) begin
         cnt <= CONV_DELAY;
         held <= {mux_select, panel_switch, 3'h5};
      end else if (cnt == 1) begin
         cnt <= 0;
         conv_done <= 1'b1;
         conv_result <= held;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule : tac_adc_model

// ==== verif/touch_adc_sequencer_tb_top.sv ====
module touch_adc_sequencer_tb_top
   import tac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, sys_rst = 1'b1, low_precision_select = 1'b0, sleep_mode = 1'b0;
   logic touch_enable = 1'b0, pen_detect_enable = 1'b0, timer_enable = 1'b0;
   logic soft_trigger = 1'b0, external_conversion_trigger = 1'b0, pen_sense = 1'b0, dma_ack = 1'b0;
   logic [7:0] channel_enable_register = 8'h00;
   logic [5:0] prescale = 6'h00;
   logic [6:0] startup_field = 7'h00;
   logic [3:0] sample_hold_cycles = 4'h1, touch_sample_hold_cycles = 4'h2, read_index = 4'h0;
   logic [15:0] timer_period = 16'h00c8;
   logic conv_done, cell_awake, conv_start, pen_switch, dma_req, dma_byte_size;
   logic busy, seq_done, pen_contact, irq;
   logic [9:0] conv_result, last_result, read_data, dma_data;
   logic [2:0] mux_select;
   logic [7:0] pin_takeover, input_grounded;
   logic [3:0] panel_switch, last_index;
   int n_fail = 0, compares = 0, cycles = 0;
   int t_trig = 0, t_conv = 0;
   logic [6:0] order[$];
   always #5 core_clk = ~core_clk;
   tac_sequencer dut (.core_clk(core_clk), .sys_rst(sys_rst),
      .channel_enable_register(channel_enable_register),
      .low_precision_select(low_precision_select), .sleep_mode(sleep_mode),
      .touch_enable(touch_enable), .pen_detect_enable(pen_detect_enable),
      .prescale(prescale), .startup_field(startup_field),
      .sample_hold_cycles(sample_hold_cycles),
      .touch_sample_hold_cycles(touch_sample_hold_cycles), .timer_period(timer_period),
      .timer_enable(timer_enable), .soft_trigger(soft_trigger),
      .external_conversion_trigger(external_conversion_trigger), .pen_sense(pen_sense),
      .conv_done(conv_done), .conv_result(conv_result), .read_index(read_index),
      .dma_ack(dma_ack), .mux_select(mux_select), .pin_takeover(pin_takeover),
      .input_grounded(input_grounded), .cell_awake(cell_awake), .conv_start(conv_start),
      .panel_switch(panel_switch), .pen_switch(pen_switch), .last_result(last_result),
      .last_index(last_index), .read_data(read_data), .dma_req(dma_req),
      .dma_byte_size(dma_byte_size), .dma_data(dma_data), .busy(busy),
      .seq_done(seq_done), .pen_contact(pen_contact), .irq(irq));
   tac_adc_model model (.core_clk(core_clk), .conv_start(conv_start),
      .mux_select(mux_select), .panel_switch(panel_switch), .conv_done(conv_done),
      .conv_result(conv_result));
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic complete_run();
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : complete_run
   // A cycle ceiling well above the few hundred cycles that the tests need.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         complete_run();
      end
      if (!sys_rst && conv_start === 1'b1) begin
         order.push_back({mux_select, panel_switch});
         t_conv = cycles;
         if (sleep_mode) check("cell_awake", 16'(cell_awake), 16'h1);
      end
   end
   task automatic wait_done();
      int i;
      for (i = 0; i < 600; i++) begin
         @(negedge core_clk);
         if (seq_done === 1'b1) break;
      end
      check("seq_done", 16'(seq_done), 16'h1);
      check("irq", 16'(irq), 16'h1);
      check("busy", 16'(busy), 16'h0);
   endtask : wait_done
   task automatic rd(input logic [3:0] idx, input logic [9:0] exp);
      read_index = idx;
      @(negedge core_clk);
      check("read_data", 16'(read_data), 16'(exp));
   endtask : rd
   function automatic logic [9:0] res(input logic [2:0] ch, input logic [3:0] pan);
      return {ch, pan, 3'h5};
   endfunction : res
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      check("grounded", 16'(input_grounded), 16'h00ff);
      channel_enable_register = 8'h85;
      @(negedge core_clk);
      check("takeover", 16'(pin_takeover), 16'h0085);
      check("grounded", 16'(input_grounded), 16'h007a);
      soft_trigger = 1'b1;
      @(negedge core_clk);
      soft_trigger = 1'b0;
      repeat (4) @(negedge core_clk);
      soft_trigger = 1'b1;
      @(negedge core_clk);
      soft_trigger = 1'b0;
      check("busy", 16'(busy), 16'h1);
      wait_done();
      check("count", 16'(order.size()), 16'h3);
      check("order0", 16'(order[0]), 16'h00);
      check("order1", 16'(order[1]), 16'h20);
      check("order2", 16'(order[2]), 16'h70);
      rd(4'h0, res(3'h0, 4'h0));
      rd(4'h2, res(3'h2, 4'h0));
      check("last_result", 16'(last_result), 16'(res(3'h7, 4'h0)));
      check("last_index", 16'(last_index), 16'h7);
      check("dma_data", 16'(dma_data), 16'(res(3'h7, 4'h0)));
      check("dma_req", 16'(dma_req), 16'h1);
      check("dma_size", 16'(dma_byte_size), 16'h0);
      dma_ack = 1'b1;
      @(negedge core_clk);
      dma_ack = 1'b0;
      check("dma_req", 16'(dma_req), 16'h0);
      order.delete();
      low_precision_select = 1'b1;
      sleep_mode = 1'b1;
      channel_enable_register = 8'h10;
      startup_field = 7'h01;
      repeat (3) @(negedge core_clk);
      check("cell_awake", 16'(cell_awake), 16'h0);
      external_conversion_trigger = 1'b1;
      t_trig = cycles;
      wait_done();
      external_conversion_trigger = 1'b0;
      check("wake_time", 16'(t_conv - t_trig), 16'h0016);
      rd(4'h4, res(3'h4, 4'h0) >> 2);
      check("dma_size", 16'(dma_byte_size), 16'h1);
      check("cell_awake", 16'(cell_awake), 16'h0);
      order.delete();
      sleep_mode = 1'b0;
      channel_enable_register = 8'h00;
      touch_enable = 1'b1;
      timer_enable = 1'b1;
      wait_done();
      timer_enable = 1'b0;
      check("touch_count", 16'(order.size()), 16'h4);
      check("touch0", 16'(order[0]), 16'h13);
      check("touch1", 16'(order[1]), 16'h13);
      check("touch2", 16'(order[2]), 16'h3c);
      check("touch3", 16'(order[3]), 16'h3c);
      rd(4'h8, res(3'h1, 4'h3));
      rd(4'hb, res(3'h3, 4'hc));
      check("panel_idle", 16'(panel_switch), 16'h0);
      touch_enable = 1'b0;
      pen_detect_enable = 1'b1;
      pen_sense = 1'b1;
      repeat (6) @(negedge core_clk);
      check("pen_switch", 16'(pen_switch), 16'h1);
      check("pen_contact", 16'(pen_contact), 16'h1);
      check("irq_quiet", 16'(irq), 16'h0);
      pen_sense = 1'b0;
      repeat (4) @(negedge core_clk);
      check("pen_lift", 16'(pen_contact), 16'h0);
      complete_run();
   end
endmodule : touch_adc_sequencer_tb_top
